//--- rtl/acb_pkg.sv
// Shared constants for the comparator B control block.
package acb_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] ACB_IDX_CTRL       = 8'h9F;
    localparam logic [7:0] ACB_IDX_IRQ_STATUS = 8'hA0;
    localparam logic [7:0] ACB_IDX_IRQ_CLEAR  = 8'hA1;
    localparam logic [7:0] ACB_IDX_IRQ_ENABLE = 8'hA2;

    // Control and status register field positions and reset value.
    localparam int         ACB_SEL_HI    = 7;
    localparam int         ACB_SEL_LO    = 6;
    localparam int         ACB_CONNECT   = 5;
    localparam int         ACB_FLAG      = 4;
    localparam int         ACB_ON        = 3;
    localparam int         ACB_MODE_HI   = 2;
    localparam logic [7:0] ACB_CTRL_RESET = 8'hC0;

    // Interrupt status layout, shared by the status, clear and enable registers.
    localparam int         ACB_IRQ_CFG    = 0;
    localparam int         ACB_IRQ_CMP    = 6;
    localparam logic [7:0] ACB_IRQ_MASK   = 8'h41;
    localparam logic [7:0] ACB_IRQ_RESET  = 8'h00;

    // Trigger mode encodings.
    localparam logic [2:0] ACB_MODE_LOW      = 3'h0;
    localparam logic [2:0] ACB_MODE_RISE     = 3'h1;
    localparam logic [2:0] ACB_MODE_DB_TOG   = 3'h2;
    localparam logic [2:0] ACB_MODE_DB_RISE  = 3'h3;
    localparam logic [2:0] ACB_MODE_FALL     = 3'h4;
    localparam logic [2:0] ACB_MODE_TOG      = 3'h5;
    localparam logic [2:0] ACB_MODE_DB_FALL  = 3'h6;
    localparam logic [2:0] ACB_MODE_HIGH     = 3'h7;

    // True when an index names one of the block's registers.
    function automatic logic acb_is_mapped(input logic [7:0] idx);
        acb_is_mapped = (idx == ACB_IDX_CTRL) || (idx == ACB_IDX_IRQ_STATUS) ||
                        (idx == ACB_IDX_IRQ_CLEAR) || (idx == ACB_IDX_IRQ_ENABLE);
    endfunction : acb_is_mapped

    // One-hot pin route for a two-bit channel select.
    function automatic logic [3:0] acb_onehot(input logic [1:0] sel);
        acb_onehot = 4'h1 << sel;
    endfunction : acb_onehot

endpackage : acb_pkg

//--- rtl/acb_reg_if.sv
// Register access carrier between the bus port and the register file.
`timescale 1ns/100ps
interface acb_reg_if;
    logic       wr_stb;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus  (output wr_stb, output idx, output wdata, input rdata);
    modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface : acb_reg_if

//--- rtl/acb_wb_port.sv
// Classic Wishbone slave port that turns bus cycles into register strobes.
`timescale 1ns/100ps
module acb_wb_port
    import acb_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Register side.
    acb_reg_if.bus           rif
);
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        hit;
    logic        req;

    // Decode; unmapped or misaligned addresses are acknowledged, read zero and ignore writes.
    assign req       = wb_cyc_i && wb_stb_i;
    assign rif.idx   = wb_adr_i[9:2];
    assign hit       = (wb_adr_i[11:10] == 2'h0) && (wb_adr_i[1:0] == 2'h0) && acb_is_mapped(wb_adr_i[9:2]);
    assign rif.wdata = wb_dat_i[7:0];
    // The write lands on the edge where the master samples ack.
    assign rif.wr_stb = req && wb_we_i && ack_r && hit && wb_sel_i[0];

    // Ack one cycle after the request, dropped in the cycle after it.
    always_comb
    begin
        ack_nxt = req && !ack_r;
        dat_nxt = dat_r;
        if (req && !ack_r)
        begin
            dat_nxt = (hit && !wb_we_i) ? {24'h00_0000, rif.rdata} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : acb_wb_port

//--- rtl/acb_trigger.sv
// Trigger mode detector with optional timer-paced debouncing.
`timescale 1ns/100ps
module acb_trigger
    import acb_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control.
    input  wire logic       comp_on_i,
    input  wire logic [2:0] mode_i,
    input  wire logic       sample_tick_i,
    // Comparator.
    input  wire logic       comp_raw_i,
    output logic            comp_out_o,
    output logic            event_o
);
    logic comp_q;
    logic prev_r, prev_nxt;
    logic samp_r, samp_nxt;
    logic stable_r, stable_nxt;
    logic deb_rise, deb_fall, rise, fall;

    // Disabled comparator reads as low.
    assign comp_q = comp_on_i && comp_raw_i; // R06

    // Debounce: a level counts only when two timer samples in a row agree.
    always_comb
    begin
        prev_nxt   = comp_q;
        samp_nxt   = samp_r;
        stable_nxt = stable_r;
        deb_rise   = 1'b0;
        deb_fall   = 1'b0;
        if (!comp_on_i)
        begin
            samp_nxt   = 1'b0;
            stable_nxt = 1'b0;
        end
        else if (sample_tick_i)
        begin
            samp_nxt = comp_q;
            if ((comp_q == samp_r) && (comp_q != stable_r))
            begin
                stable_nxt = comp_q;
                deb_rise   = comp_q;
                deb_fall   = !comp_q;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_r   <= 1'b0;
            samp_r   <= 1'b0;
            stable_r <= 1'b0;
        end
        else
        begin
            prev_r   <= prev_nxt;
            samp_r   <= samp_nxt;
            stable_r <= stable_nxt;
        end
    end

    assign rise = comp_q && !prev_r;
    assign fall = !comp_q && prev_r;

    // Mode decode; no event while the comparator is off.
    always_comb
    begin
        case (mode_i) // R07
            ACB_MODE_LOW:     event_o = !comp_q;
            ACB_MODE_RISE:    event_o = rise;
            ACB_MODE_DB_TOG:  event_o = deb_rise || deb_fall;
            ACB_MODE_DB_RISE: event_o = deb_rise;
            ACB_MODE_FALL:    event_o = fall;
            ACB_MODE_TOG:     event_o = rise || fall;
            ACB_MODE_DB_FALL: event_o = deb_fall;
            ACB_MODE_HIGH:    event_o = comp_q;
            default:          event_o = 1'b0;
        endcase
        event_o = event_o && comp_on_i; // R06
    end

    assign comp_out_o = prev_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RISE_EVENT: assert property (comp_on_i && mode_i == ACB_MODE_RISE && comp_q && !prev_r |-> event_o) // R07
        else $error("rising edge gave no event");
    AST_HIGH_LEVEL: assert property (comp_on_i && mode_i == ACB_MODE_HIGH |-> event_o == comp_raw_i) // R07
        else $error("high level mode mismatch");
    AST_DB_NEEDS_TICK: assert property (mode_i == ACB_MODE_DB_RISE && !sample_tick_i |-> !event_o) // R07
        else $error("debounced event without sample tick");
endmodule : acb_trigger

//--- rtl/acb_top.sv
// Comparator B control and status register file with interrupt logic.
`timescale 1ns/100ps
// Function
// R01 - The control and status register sits at index 9F, resets to C0 and holds select, connect, flag, enable and mode.
// R02 - While connect is set the selected analog pin is routed to the comparator.
// R03 - While connect is clear every analog pin is isolated from the comparator.
// R04 - Software clears connect before changing the channel or reference select.
// R05 - The flag sets when the enabled comparator meets the trigger mode, only software clears it, and bit 6 gates the interrupt.
// R06 - Clearing enable forces the output low and blocks events, and while enabled the input-only pins lose their digital buffers.
// R07 - The three-bit mode selects low, rise, debounced toggle, debounced rise, fall, toggle, debounced fall or high.
module acb_top
    import acb_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Analog comparator and pin configuration.
    input  wire logic        comp_raw_i,
    input  wire logic        timer1_tick_i,
    input  wire logic [3:0]  input_only_i,
    // Comparator control.
    output logic      [1:0]  pos_sel_o,
    output logic      [3:0]  pin_route_o,
    output logic             comp_on_o,
    output logic      [2:0]  trigger_mode_o,
    output logic             comp_out_o,
    output logic      [3:0]  dig_in_dis_o,
    // Interrupt.
    output logic             irq_o
);
    acb_reg_if rif ();

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] irq_stat_r;
    logic [7:0] irq_stat_nxt;
    logic [7:0] irq_en_r;
    logic [7:0] irq_en_nxt;
    logic       cmp_event;
    logic       wr_ctrl;
    logic       wr_clear;
    logic       wr_enable;
    logic       cfg_violation;
    logic [1:0] positive_input_select;
    logic       input_connect;
    logic       compare_event_flag;
    logic       comparator_on;
    logic [2:0] trigger_mode;

    // Bus port; it answers every request one cycle after it is raised.
    acb_wb_port u_wb
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rif      (rif)
    );

    // Field views of the control and status register.
    assign positive_input_select = ctrl_r[ACB_SEL_HI:ACB_SEL_LO];
    assign input_connect         = ctrl_r[ACB_CONNECT];
    assign compare_event_flag    = ctrl_r[ACB_FLAG];
    assign comparator_on         = ctrl_r[ACB_ON];
    assign trigger_mode          = ctrl_r[ACB_MODE_HI:0];

    // Trigger detector, paced by the timer tick for the debounced modes.
    acb_trigger u_trig
    (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .comp_on_i     (comparator_on),
        .mode_i        (trigger_mode),
        .sample_tick_i (timer1_tick_i),
        .comp_raw_i    (comp_raw_i),
        .comp_out_o    (comp_out_o),
        .event_o       (cmp_event)
    );

    // Write strobes per register.
    assign wr_ctrl   = rif.wr_stb && (rif.idx == ACB_IDX_CTRL);
    assign wr_clear  = rif.wr_stb && (rif.idx == ACB_IDX_IRQ_CLEAR);
    assign wr_enable = rif.wr_stb && (rif.idx == ACB_IDX_IRQ_ENABLE);

    // Changing the select while still connected glitches the comparator, so flag it.
    assign cfg_violation = wr_ctrl && input_connect && rif.wdata[ACB_CONNECT] &&
                           (rif.wdata[ACB_SEL_HI:ACB_SEL_LO] != positive_input_select); // R04

    // Control register next value; the flag only clears by a zero write or the clear register.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt[ACB_SEL_HI:ACB_SEL_LO] = rif.wdata[ACB_SEL_HI:ACB_SEL_LO]; // R01
            ctrl_nxt[ACB_CONNECT]           = rif.wdata[ACB_CONNECT];
            ctrl_nxt[ACB_ON]                = rif.wdata[ACB_ON];
            ctrl_nxt[ACB_MODE_HI:0]         = rif.wdata[ACB_MODE_HI:0];
            if (!rif.wdata[ACB_FLAG])
            begin
                ctrl_nxt[ACB_FLAG] = 1'b0;
            end
        end
        if (wr_clear && rif.wdata[ACB_IRQ_CMP])
        begin
            ctrl_nxt[ACB_FLAG] = 1'b0;
        end
        // A new event wins over a clear in the same cycle.
        if (cmp_event)
        begin
            ctrl_nxt[ACB_FLAG] = 1'b1; // R05
        end
    end

    // Interrupt status and enable next values; set wins over clear here too.
    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        irq_en_nxt   = irq_en_r;
        if (wr_clear && rif.wdata[ACB_IRQ_CFG])
        begin
            irq_stat_nxt[ACB_IRQ_CFG] = 1'b0;
        end
        if (cfg_violation)
        begin
            irq_stat_nxt[ACB_IRQ_CFG] = 1'b1; // R04
        end
        irq_stat_nxt[ACB_IRQ_CMP] = ctrl_nxt[ACB_FLAG]; // R05
        if (wr_enable)
        begin
            irq_en_nxt = rif.wdata & ACB_IRQ_MASK;
        end
    end

    // Register storage.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r     <= ACB_CTRL_RESET; // R01
            irq_stat_r <= ACB_IRQ_RESET;
            irq_en_r   <= ACB_IRQ_RESET;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
        end
    end

    // Read mux; the clear register is write-only and reads zero.
    always_comb
    begin
        case (rif.idx)
            ACB_IDX_CTRL:       rif.rdata = ctrl_r; // R01
            ACB_IDX_IRQ_STATUS: rif.rdata = irq_stat_r;
            ACB_IDX_IRQ_ENABLE: rif.rdata = irq_en_r;
            default:            rif.rdata = 8'h00;
        endcase
    end

    // Pin routing follows the connect bit directly from the register.
    assign pin_route_o    = input_connect ? acb_onehot(positive_input_select) : 4'h0; // R02 R03
    assign pos_sel_o      = positive_input_select;
    assign comp_on_o      = comparator_on;
    assign trigger_mode_o = trigger_mode;
    // Input-only pins lose their digital buffer while the comparator runs, to save leakage.
    assign dig_in_dis_o   = comparator_on ? input_only_i : 4'h0; // R06
    assign irq_o          = |(irq_stat_r & irq_en_r); // R05

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RESET_VALUE: assert property (disable iff (1'b0) rst_i |=> ctrl_r == ACB_CTRL_RESET) // R01
        else $error("control register not at reset value");
    AST_CTRL_WRITE: assert property (wr_ctrl && !cmp_event |=> // R01
                                     ctrl_r == ($past(rif.wdata) & ($past(ctrl_r) | 8'hEF)))
        else $error("control write not stored");
    AST_ROUTE_ON: assert property (input_connect |-> pin_route_o == acb_onehot(positive_input_select)) // R02
        else $error("selected pin not routed");
    AST_ISOLATE: assert property (!input_connect |-> pin_route_o == 4'h0) // R03
        else $error("pin routed while disconnected");
    AST_FLAG_SET: assert property (cmp_event |=> compare_event_flag ##0 irq_stat_r[ACB_IRQ_CMP]) // R05
        else $error("event did not set flag");
    AST_FLAG_ONLY_EVENT: assert property (!compare_event_flag && !cmp_event |=> !compare_event_flag) // R05
        else $error("flag set without event");
    AST_FLAG_STICKY: assert property (compare_event_flag && !wr_ctrl && !wr_clear |=> compare_event_flag) // R05
        else $error("flag lost without software clear");
    AST_IRQ_GATE: assert property (compare_event_flag && !irq_en_r[ACB_IRQ_CMP] && !irq_stat_r[ACB_IRQ_CFG] // R05
                                   |-> !irq_o)
        else $error("interrupt not gated by enable bit");
    AST_IRQ_LEVEL: assert property (irq_stat_r[ACB_IRQ_CMP] && irq_en_r[ACB_IRQ_CMP] |-> irq_o) // R05
        else $error("enabled flag gives no interrupt");
    AST_OFF_LOW: assert property (!comparator_on |=> !comp_out_o) // R06
        else $error("output not forced low when disabled");
    AST_OFF_NO_EVENT: assert property (!comparator_on |-> !cmp_event) // R06
        else $error("event while disabled");
    AST_DIG_DIS: assert property (dig_in_dis_o == (comparator_on ? input_only_i : 4'h0)) // R06
        else $error("digital buffer control wrong");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) // R01
        else $error("ack held longer than one cycle");

    // Bus answers, read data, refused writes, flag and violation upkeep, routing and modes.
    AST_ACK_NEXT: assert property ( // R01
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");

    AST_IDLE_NO_ACK: assert property ( // R01
        !wb_cyc_i |=> !wb_ack_o)
        else $error("ack without cycle");

    AST_WR_ON_ACK: assert property ( // R01
        rif.wr_stb |-> wb_ack_o)
        else $error("write outside ack");

    AST_DAT_UPPER: assert property ( // R01
        wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper lanes not zero");

    AST_RD_CTRL: assert property ( // R01
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == {2'b00, ACB_IDX_CTRL, 2'b00}
        |=> wb_dat_o[7:0] == $past(ctrl_r))
        else $error("control read wrong");

    AST_RD_STATUS: assert property ( // R05
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == {2'b00, ACB_IDX_IRQ_STATUS, 2'b00}
        |=> wb_dat_o[7:0] == $past(irq_stat_r))
        else $error("status read wrong");

    AST_RD_UNMAPPED: assert property ( // R01
        wb_cyc_i && wb_stb_i && !wb_ack_o && !acb_is_mapped(wb_adr_i[9:2]) |=> wb_dat_o == 32'h0000_0000)
        else $error("hole not read zero");

    AST_STAT_RO: assert property ( // R01
        rif.wr_stb && rif.idx == ACB_IDX_IRQ_STATUS && !cmp_event |=> $stable(irq_stat_r))
        else $error("status changed by write");

    AST_SEL0_REFUSED: assert property ( // R01
        wb_ack_o && wb_we_i && !wb_sel_i[0] && !cmp_event |=> $stable(ctrl_r))
        else $error("laneless write stored");

    AST_CTRL_HOLD: assert property ( // R01
        !wr_ctrl && !wr_clear && !cmp_event |=> $stable(ctrl_r))
        else $error("control changed alone");

    AST_FLAG_CLEAR: assert property ( // R05
        wr_clear && rif.wdata[ACB_IRQ_CMP] && !cmp_event |=> !compare_event_flag)
        else $error("clear left flag set");

    AST_FLAG_ZERO: assert property ( // R05
        wr_ctrl && !rif.wdata[ACB_FLAG] && !cmp_event |=> !compare_event_flag)
        else $error("zero write left flag");

    AST_MIRROR: assert property ( // R05
        irq_stat_r[ACB_IRQ_CMP] == compare_event_flag)
        else $error("status copy differs");

    AST_EN_LAYOUT: assert property ( // R05
        (irq_en_r & ~ACB_IRQ_MASK) == 8'h00)
        else $error("undefined enable bit");

    AST_IRQ_QUIET: assert property ( // R05
        (irq_stat_r & irq_en_r) == 8'h00 |-> !irq_o)
        else $error("interrupt without cause");

    AST_CFG_SET: assert property ( // R04
        cfg_violation |=> irq_stat_r[ACB_IRQ_CFG])
        else $error("violation not kept");

    AST_CFG_STICKY: assert property ( // R04
        irq_stat_r[ACB_IRQ_CFG] && !wr_clear |=> irq_stat_r[ACB_IRQ_CFG])
        else $error("violation lost");

    AST_ROUTE_ONEHOT: assert property ( // R02
        $onehot0(pin_route_o))
        else $error("several pins routed");

    AST_LOW_LEVEL: assert property ( // R07
        comparator_on && trigger_mode == ACB_MODE_LOW && !comp_raw_i |-> cmp_event)
        else $error("low level no event");

    AST_TOG_EDGE: assert property ( // R07
        comparator_on && trigger_mode == ACB_MODE_TOG && comp_raw_i != comp_out_o |-> cmp_event)
        else $error("toggle no event");

    COV_CTRL_WRITE: cover property (wr_ctrl ##1 comparator_on && input_connect);
    COV_FLAG_IRQ: cover property (cmp_event ##1 irq_o);
    COV_CFG_VIOL: cover property (cfg_violation ##1 irq_stat_r[ACB_IRQ_CFG]);
    COV_SET_CLEAR: cover property (cmp_event && wr_clear);
    COV_DB_EVENT: cover property (trigger_mode == ACB_MODE_DB_TOG && cmp_event);
endmodule : acb_top

//--- dv/tb.sv
// Self-checking bench for the comparator B control block over classic Wishbone.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb
    import acb_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    logic        comp_raw_i;
    logic        timer1_tick_i;
    logic [3:0]  input_only_i;
    wire  [1:0]  pos_sel_o;
    wire  [3:0]  pin_route_o;
    wire         comp_on_o;
    wire  [2:0]  trigger_mode_o;
    wire         comp_out_o;
    wire  [3:0]  dig_in_dis_o;
    wire         irq_o;
    int          miscompares = 0;
    int          checks_done = 0;
    logic [31:0] rdat;

    acb_top i_acb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_raw_i(comp_raw_i), .timer1_tick_i(timer1_tick_i),
        .input_only_i(input_only_i), .pos_sel_o(pos_sel_o), .pin_route_o(pin_route_o),
        .comp_on_o(comp_on_o), .trigger_mode_o(trigger_mode_o), .comp_out_o(comp_out_o),
        .dig_in_dis_o(dig_in_dis_o), .irq_o(irq_o));

    // Free-running 40 MHz system clock.
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // One classic cycle; the request is held until ack is sampled high, then released for one idle cycle.
    task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] dat,
                           input logic [3:0] sel, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h00_0000, dat};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb_xfer

    // Full-byte register write.
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        logic [31:0] dummy;
        wb_xfer(1'b1, idx, dat, 4'hF, dummy);
    endtask : wr

    // Register read compared against an expected byte; upper bits must read zero.
    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        wb_xfer(1'b0, idx, 8'h00, 4'hF, rdat);
        `CHK(nm, {24'h00_0000, exp}, rdat)
    endtask : rd_chk

    // One timer sample pulse followed by a quiet cycle.
    task automatic pulse();
        timer1_tick_i <= 1'b1;
        @(posedge clk_i);
        timer1_tick_i <= 1'b0;
        @(posedge clk_i);
    endtask : pulse

    // Reset values, unmapped space and refused writes.
    task automatic t_reset();
        rd_chk("ctrl reset", ACB_IDX_CTRL, 8'hC0);
        `CHK("pos_sel reset", 2'h3, pos_sel_o)
        `CHK("route reset", 4'h0, pin_route_o)
        rd_chk("status reset", ACB_IDX_IRQ_STATUS, 8'h00);
        wr(8'h10, 8'hFF);
        rd_chk("unmapped", 8'h10, 8'h00);
        wb_xfer(1'b1, ACB_IDX_CTRL, 8'h2F, 4'hE, rdat);
        rd_chk("ctrl sel0 low", ACB_IDX_CTRL, 8'hC0);
        wr(ACB_IDX_IRQ_STATUS, 8'hFF);
        rd_chk("status read only", ACB_IDX_IRQ_STATUS, 8'h00);
    endtask : t_reset

    // Channel routing follows connect, and a select change under connect is flagged.
    task automatic t_route();
        wr(ACB_IDX_CTRL, 8'h80);
        `CHK("route isolated", 4'h0, pin_route_o)
        `CHK("pos_sel two", 2'h2, pos_sel_o)
        wr(ACB_IDX_CTRL, 8'hA0);
        `CHK("route pin two", 4'h4, pin_route_o)
        rd_chk("no violation", ACB_IDX_IRQ_STATUS, 8'h00);
        wr(ACB_IDX_CTRL, 8'h60);
        `CHK("route pin one", 4'h2, pin_route_o)
        rd_chk("violation", ACB_IDX_IRQ_STATUS, 8'h01);
        wr(ACB_IDX_IRQ_CLEAR, 8'h01);
        rd_chk("violation cleared", ACB_IDX_IRQ_STATUS, 8'h00);
        wr(ACB_IDX_CTRL, 8'h00);
        `CHK("route off", 4'h0, pin_route_o)
    endtask : t_route

    // Enable gates the output, the event path and the digital buffers.
    task automatic t_enable();
        input_only_i <= 4'hA;
        comp_raw_i   <= 1'b1;
        wr(ACB_IDX_CTRL, 8'h01);
        `CHK("buffers on", 4'h0, dig_in_dis_o)
        comp_raw_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        comp_raw_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("out forced low", 1'b0, comp_out_o)
        rd_chk("no event when off", ACB_IDX_CTRL, 8'h01);
        wr(ACB_IDX_CTRL, 8'h09);
        `CHK("buffers off", 4'hA, dig_in_dis_o)
        `CHK("on output", 1'b1, comp_on_o)
        repeat (2) @(posedge clk_i);
        `CHK("out follows", 1'b1, comp_out_o)
        wr(ACB_IDX_CTRL, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK("out low again", 1'b0, comp_out_o)
    endtask : t_enable

    // One input change, then the flag is judged and cleared.
    task automatic step(input logic v, input logic f, input logic deb);
        comp_raw_i <= v;
        repeat (3) @(posedge clk_i);
        if (deb)
        begin
            wb_xfer(1'b0, ACB_IDX_CTRL, 8'h00, 4'hF, rdat);
            `CHK("flag before ticks", 1'b0, rdat[ACB_FLAG])
            pulse();
            pulse();
        end
        wb_xfer(1'b0, ACB_IDX_CTRL, 8'h00, 4'hF, rdat);
        `CHK("flag", f, rdat[ACB_FLAG])
        wr(ACB_IDX_IRQ_CLEAR, 8'h40);
    endtask : step

    // A trigger mode: start level, then two opposite changes with their expected flags.
    task automatic t_mode(input logic [2:0] m, input logic s, input logic f1, input logic f2, input logic deb);
        comp_raw_i <= s;
        wr(ACB_IDX_CTRL, 8'h00);
        wr(ACB_IDX_CTRL, {5'b00001, m});
        `CHK("mode output", m, trigger_mode_o)
        repeat (3) @(posedge clk_i);
        wr(ACB_IDX_IRQ_CLEAR, 8'h40);
        wb_xfer(1'b0, ACB_IDX_CTRL, 8'h00, 4'hF, rdat);
        `CHK("flag idle", 1'b0, rdat[ACB_FLAG])
        step(~s, f1, deb);
        step(s, f2, deb);
    endtask : t_mode

    // Interrupt raised, masked, unmasked and cleared.
    task automatic t_irq();
        comp_raw_i <= 1'b0;
        wr(ACB_IDX_CTRL, 8'h09);
        wr(ACB_IDX_IRQ_ENABLE, 8'hFF);
        rd_chk("enable layout", ACB_IDX_IRQ_ENABLE, 8'h41);
        wr(ACB_IDX_IRQ_ENABLE, 8'h00);
        comp_raw_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq_o)
        rd_chk("status flag", ACB_IDX_IRQ_STATUS, 8'h40);
        wr(ACB_IDX_IRQ_ENABLE, 8'h40);
        `CHK("irq raised", 1'b1, irq_o)
        wr(ACB_IDX_CTRL, 8'h09);
        `CHK("ctrl bit4 clears", 1'b0, irq_o)
        rd_chk("status clear", ACB_IDX_IRQ_STATUS, 8'h00);
        wr(ACB_IDX_IRQ_ENABLE, 8'h00);
    endtask : t_irq

    // Watchdog; the whole sequence needs a few hundred cycles.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        close_out();
    end

    // Main sequence: reset for five cycles, then every scenario in turn.
    initial
    begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        comp_raw_i = 1'b0;
        timer1_tick_i = 1'b0;
        input_only_i = 4'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_route();
        t_enable();
        t_mode(ACB_MODE_LOW, 1'b1, 1'b1, 1'b1, 1'b0);
        t_mode(ACB_MODE_RISE, 1'b0, 1'b1, 1'b0, 1'b0);
        t_mode(ACB_MODE_FALL, 1'b1, 1'b1, 1'b0, 1'b0);
        t_mode(ACB_MODE_TOG, 1'b0, 1'b1, 1'b1, 1'b0);
        t_mode(ACB_MODE_HIGH, 1'b0, 1'b1, 1'b1, 1'b0);
        t_mode(ACB_MODE_DB_TOG, 1'b0, 1'b1, 1'b1, 1'b1);
        t_mode(ACB_MODE_DB_RISE, 1'b0, 1'b1, 1'b0, 1'b1);
        t_mode(ACB_MODE_DB_FALL, 1'b0, 1'b0, 1'b1, 1'b1);
        t_irq();
        close_out();
    end
endmodule : tb
